// [include/aimr_pkg.sv]
// Constants for the converter interrupt mask and channel result bank.
// Assumes a 32-bit classic Wishbone slave decoded on byte addresses.
`default_nettype none
package aimr_pkg;
    localparam int unsigned NUM_CH        = 4;   // Converter channels
    localparam int unsigned DATA_W        = 10;  // Result data width
    localparam int unsigned ADDR_W        = 8;   // Byte address width
    localparam int unsigned BUS_W         = 32;
    localparam int unsigned SEL_W         = 4;
    localparam int unsigned LANE_W        = 8;
    // Register byte offsets
    localparam logic [7:0]  OFS_STATUS    = 8'h1c;
    localparam logic [7:0]  OFS_IRQ_SET   = 8'h24;
    localparam logic [7:0]  OFS_IRQ_CLR   = 8'h28;
    localparam logic [7:0]  OFS_IRQ_VIEW  = 8'h2c;
    localparam logic [7:0]  OFS_RESULT0   = 8'h30;
    localparam logic [7:0]  RESULT_STRIDE = 8'h04;
    // Field positions shared by status, set, clear and view registers
    localparam int unsigned POS_DONE      = 0;
    localparam int unsigned POS_OVR       = 8;
    localparam int unsigned POS_READY     = 16;
    localparam int unsigned POS_GOVR      = 17;
    localparam int unsigned POS_RXEND     = 18;
    localparam int unsigned POS_RXFULL    = 19;
    localparam logic [31:0] IRQ_BITS      = 32'h000f0f0f;
    localparam logic [31:0] MASK_RESET    = 32'h00000000;
    localparam logic [DATA_W-1:0] RESULT_RESET = 10'h000;
endpackage : aimr_pkg
`default_nettype wire

// [include/aimr_cap_if.sv]
// Carrier between the register front end and the channel result bank.
// Assumes both ends run on the same clock and reset.
`timescale 1ns/1ns
`default_nettype none
interface aimr_cap_if #(
    parameter int unsigned NCH = aimr_pkg::NUM_CH,
    parameter int unsigned DW  = aimr_pkg::DATA_W
);
    logic [NCH-1:0]         done;    // Conversion end, one pulse per channel
    logic [NCH-1:0]         chan_en; // Channel enable levels
    logic [NCH-1:0]         clr;     // Done flag clear pulses
    logic [DW-1:0]          data;    // Value of the ending conversion
    logic [NCH-1:0]         eoc;     // Done flags
    logic [NCH-1:0][DW-1:0] result;  // Captured values

    modport ctl (
        output done,
        output chan_en,
        output clr,
        output data,
        input  eoc,
        input  result
    );

    modport bank (
        input  done,
        input  chan_en,
        input  clr,
        input  data,
        output eoc,
        output result
    );
endinterface : aimr_cap_if
`default_nettype wire

// [hdl/aimr_result_bank.sv]
// Per-channel result capture and conversion done flags.
// Assumes done pulses and enables come from logic on the same clock.
`timescale 1ns/1ns
`default_nettype none
module aimr_result_bank #(
    parameter int unsigned NCH = aimr_pkg::NUM_CH,
    parameter int unsigned DW  = aimr_pkg::DATA_W
) (
    input  wire logic  i_clock,
    input  wire logic  i_rst,
    aimr_cap_if.bank   cap
);

    for (genvar k = 0; k < NCH; k++) begin : g_ch
        // Capture only for an enabled channel; otherwise hold
        always_ff @(posedge i_clock) begin
            if (i_rst) begin
                cap.result[k] <= aimr_pkg::RESULT_RESET;
            end else if (cap.done[k] && cap.chan_en[k]) begin
                cap.result[k] <= cap.data;
            end
        end

        // Done flag; a new completion wins over a clear
        always_ff @(posedge i_clock) begin
            if (i_rst) begin
                cap.eoc[k] <= 1'b0;
            end else if (!cap.chan_en[k]) begin
                cap.eoc[k] <= 1'b0;
            end else if (cap.done[k]) begin
                cap.eoc[k] <= 1'b1;
            end else if (cap.clr[k]) begin
                cap.eoc[k] <= 1'b0;
            end
        end

        property p_capture;
            @(posedge i_clock) disable iff (i_rst)
            cap.done[k] && cap.chan_en[k] |=> cap.result[k] == $past(cap.data);
        endproperty
        a_capture: assert property (p_capture)
            else $error("result not captured");

        property p_hold;
            @(posedge i_clock) disable iff (i_rst)
            !cap.done[k] |=> $stable(cap.result[k]);
        endproperty
        a_hold: assert property (p_hold)
            else $error("result changed without a conversion");

        property p_disabled;
            @(posedge i_clock) disable iff (i_rst)
            cap.done[k] && !cap.chan_en[k] |=> $stable(cap.result[k]);
        endproperty
        a_disabled: assert property (p_disabled)
            else $error("disabled channel wrote its result");

        property p_eoc_enabled;
            @(posedge i_clock) disable iff (i_rst)
            cap.eoc[k] |-> $past(cap.chan_en[k]);
        endproperty
        a_eoc_enabled: assert property (p_eoc_enabled)
            else $error("done flag set on a disabled channel");
    end

endmodule : aimr_result_bank
`default_nettype wire

// [hdl/aimr_regs.sv]
// Interrupt set, clear and view registers, status and channel results.
// Assumes a classic Wishbone master and converter events on i_clock.
//
// Design decisions made here: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ns
`default_nettype none

module aimr_regs #(
    parameter int unsigned NCH = aimr_pkg::NUM_CH,
    parameter int unsigned DW  = aimr_pkg::DATA_W
) (
    input  wire logic                         i_clock,
    input  wire logic                         i_rst,
    // Wishbone slave
    input  wire logic                         i_wb_cyc,
    input  wire logic                         i_wb_stb,
    input  wire logic                         i_wb_we,
    input  wire logic [aimr_pkg::ADDR_W-1:0]  i_wb_adr,
    input  wire logic [aimr_pkg::BUS_W-1:0]   i_wb_dat,
    input  wire logic [aimr_pkg::SEL_W-1:0]   i_wb_sel,
    output var  logic [aimr_pkg::BUS_W-1:0]   o_wb_dat,
    output var  logic                         o_wb_ack,
    // Converter side
    input  wire logic [NCH-1:0]               i_conv_done,
    input  wire logic [DW-1:0]                i_conv_data,
    input  wire logic [NCH-1:0]               i_chan_en,
    input  wire logic [NCH-1:0]               i_chan_overrun,
    input  wire logic                         i_global_overrun,
    input  wire logic                         i_last_data_read,
    input  wire logic                         i_rx_count_end,
    input  wire logic                         i_rx_both_empty,
    // Interrupt
    output logic                              o_irq
);

    localparam int unsigned BW = aimr_pkg::BUS_W;

    logic [BW-1:0]  mask;         // irq_enable_view contents
    logic [BW-1:0]  status;       // converter_status_reg image
    logic [BW-1:0]  rd_mux;
    logic [BW-1:0]  lane_mask;
    logic [BW-1:0]  wbits;
    logic [NCH-1:0] ovr;          // channel_overrun_flag
    logic           ready;        // result_ready_flag
    logic           govr;         // global_overrun_flag
    logic [NCH-1:0] res_hit;
    logic [NCH-1:0] next_ovr;
    logic [NCH-1:0] ovr_clr;
    logic           ready_clr;
    logic           govr_clr;
    logic           req;
    logic           first;
    logic           acc;
    logic           wr;
    logic           rd;
    logic           hit_status;
    logic           stat_rd;
    logic           stat_wr;

    aimr_cap_if #(
        .NCH (NCH),
        .DW  (DW)
    ) cap ();

    // Converter events feed the result bank directly, no extra stage
    assign cap.done    = i_conv_done;
    assign cap.chan_en = i_chan_en;
    assign cap.data    = i_conv_data;

    aimr_result_bank #(
        .NCH (NCH),
        .DW  (DW)
    ) u_bank (
        .i_clock (i_clock),
        .i_rst   (i_rst),
        .cap     (cap)
    );

    // Bus phases: first cycle latches read data, ack cycle commits
    assign req   = i_wb_cyc & i_wb_stb;
    assign first = req & ~o_wb_ack;
    assign acc   = req & o_wb_ack;
    assign wr    = acc & i_wb_we;
    assign rd    = acc & ~i_wb_we;

    // Result register decode, one word per channel
    for (genvar k = 0; k < NCH; k++) begin : g_hit
        localparam logic [7:0] OFS =
            8'(aimr_pkg::OFS_RESULT0 + aimr_pkg::RESULT_STRIDE * k);
        assign res_hit[k] = (i_wb_adr == OFS);
    end

    // Byte enables widen to a bit mask; only defined bits are writable
    for (genvar b = 0; b < aimr_pkg::SEL_W; b++) begin : g_lane
        assign lane_mask[aimr_pkg::LANE_W*b +: aimr_pkg::LANE_W] =
            {aimr_pkg::LANE_W{i_wb_sel[b]}};
    end
    assign wbits = i_wb_dat & lane_mask & aimr_pkg::IRQ_BITS;

    assign hit_status = (i_wb_adr == aimr_pkg::OFS_STATUS);
    assign stat_rd    = rd & hit_status;
    assign stat_wr    = wr & hit_status;

    // Status image; reserved bits read as zero
    always_comb begin
        status = '0;
        status[aimr_pkg::POS_DONE +: NCH] = cap.eoc;
        status[aimr_pkg::POS_OVR +: NCH]  = ovr;
        status[aimr_pkg::POS_READY]       = ready;
        status[aimr_pkg::POS_GOVR]        = govr;
        status[aimr_pkg::POS_RXEND]       = i_rx_count_end;
        status[aimr_pkg::POS_RXFULL]      = i_rx_both_empty;
    end

    // Read mux; unmapped addresses and write-only registers read zero
    always_comb begin
        rd_mux = '0;
        case (i_wb_adr)
            aimr_pkg::OFS_STATUS:   rd_mux = status;
            aimr_pkg::OFS_IRQ_VIEW: rd_mux = mask;
            default:                rd_mux = '0;
        endcase
        for (int k = 0; k < NCH; k++) begin
            if (res_hit[k]) begin
                rd_mux = BW'(cap.result[k]);
            end
        end
    end

    // Ack one cycle after the strobe, dropped the cycle after
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_wb_ack <= 1'b0;
        end else begin
            o_wb_ack <= first;
        end
    end

    // Read data is a snapshot taken before the ack cycle
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_wb_dat <= '0;
        end else if (first && !i_wb_we) begin
            o_wb_dat <= rd_mux;
        end else begin
            o_wb_dat <= '0;
        end
    end

    // Enable mask: set and clear registers act on every written one in a selected byte lane and a defined bit (IRQ_BITS), view is read-only
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            mask <= aimr_pkg::MASK_RESET;
        end else if (wr && i_wb_adr == aimr_pkg::OFS_IRQ_SET) begin
            mask <= mask | wbits;
        end else if (wr && i_wb_adr == aimr_pkg::OFS_IRQ_CLR) begin
            mask <= mask & ~wbits;
        end
    end

    // Clears only hit bits that software actually saw in the snapshot,
    // so an overrun landing between snapshot and ack is not lost
    always_comb begin
        ovr_clr   = '0;
        ready_clr = i_last_data_read;
        govr_clr  = 1'b0;
        if (stat_rd) begin
            ovr_clr  = o_wb_dat[aimr_pkg::POS_OVR +: NCH];
            govr_clr = o_wb_dat[aimr_pkg::POS_GOVR];
        end
        if (stat_wr) begin
            ovr_clr   = ovr_clr | wbits[aimr_pkg::POS_OVR +: NCH];
            govr_clr  = govr_clr | wbits[aimr_pkg::POS_GOVR];
            ready_clr = ready_clr | wbits[aimr_pkg::POS_READY];
        end
    end

    // Done flags clear on a result read or a write of one to status
    for (genvar k = 0; k < NCH; k++) begin : g_clr
        assign cap.clr[k] = (rd & res_hit[k]) |
                            (stat_wr & wbits[aimr_pkg::POS_DONE + k]);
    end

    // Sticky flags; a new event wins over a clear in the same cycle
    assign next_ovr = i_chan_overrun | (ovr & ~ovr_clr);

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            ovr <= '0;
        end else begin
            ovr <= next_ovr;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            govr <= 1'b0;
        end else begin
            govr <= i_global_overrun | (govr & ~govr_clr);
        end
    end

    // Ready follows any captured result, like the last-data register
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            ready <= 1'b0;
        end else begin
            ready <= (|(i_conv_done & i_chan_en)) | (ready & ~ready_clr);
        end
    end

    // Level interrupt straight from flags, no extra latency
    assign o_irq = |(status & mask);

    property p_set;
        @(posedge i_clock) disable iff (i_rst)
        wr && i_wb_adr == aimr_pkg::OFS_IRQ_SET
        |=> mask == ($past(mask) | $past(wbits));
    endproperty
    a_set: assert property (p_set)
        else $error("set register did not add enables");

    property p_clear;
        @(posedge i_clock) disable iff (i_rst)
        wr && i_wb_adr == aimr_pkg::OFS_IRQ_CLR
        |=> mask == ($past(mask) & ~$past(wbits));
    endproperty
    a_clear: assert property (p_clear)
        else $error("clear register did not remove enables");

    property p_view;
        @(posedge i_clock) disable iff (i_rst)
        first && !i_wb_we && i_wb_adr == aimr_pkg::OFS_IRQ_VIEW
        |=> o_wb_ack && o_wb_dat == $past(mask);
    endproperty
    a_view: assert property (p_view)
        else $error("view register read wrong value");

    property p_view_ro;
        @(posedge i_clock) disable iff (i_rst)
        wr && i_wb_adr == aimr_pkg::OFS_IRQ_VIEW |=> $stable(mask);
    endproperty
    a_view_ro: assert property (p_view_ro)
        else $error("view register accepted a write");

    property p_done_gate;
        @(posedge i_clock) disable iff (i_rst)
        |(cap.eoc & mask[aimr_pkg::POS_DONE +: NCH]) |-> o_irq;
    endproperty
    a_done_gate: assert property (p_done_gate)
        else $error("enabled done flag gave no interrupt");

    property p_ovr_gate;
        @(posedge i_clock) disable iff (i_rst)
        |(ovr & mask[aimr_pkg::POS_OVR +: NCH]) |-> o_irq;
    endproperty
    a_ovr_gate: assert property (p_ovr_gate)
        else $error("enabled overrun flag gave no interrupt");

    property p_ready_gate;
        @(posedge i_clock) disable iff (i_rst)
        (ready && mask[aimr_pkg::POS_READY]) ||
        (govr && mask[aimr_pkg::POS_GOVR]) |-> o_irq;
    endproperty
    a_ready_gate: assert property (p_ready_gate)
        else $error("ready or global overrun gave no interrupt");

    property p_rx_gate;
        @(posedge i_clock) disable iff (i_rst)
        (i_rx_count_end && mask[aimr_pkg::POS_RXEND]) ||
        (i_rx_both_empty && mask[aimr_pkg::POS_RXFULL]) |-> o_irq;
    endproperty
    a_rx_gate: assert property (p_rx_gate)
        else $error("receive flag gave no interrupt");

    property p_ovr_sticky;
        @(posedge i_clock) disable iff (i_rst)
        i_chan_overrun != '0
        |=> (ovr & $past(i_chan_overrun)) == $past(i_chan_overrun);
    endproperty
    a_ovr_sticky: assert property (p_ovr_sticky)
        else $error("overrun event lost");

    property p_ovr_readclr;
        @(posedge i_clock) disable iff (i_rst)
        stat_rd && i_chan_overrun == '0
        |=> (ovr & $past(o_wb_dat[aimr_pkg::POS_OVR +: NCH])) == '0;
    endproperty
    a_ovr_readclr: assert property (p_ovr_readclr)
        else $error("status read did not clear overrun");

    // Rebuilt from the separate flags, not from the status image
    property p_irq_cause;
        @(posedge i_clock) disable iff (i_rst)
        o_irq |-> (cap.eoc & mask[aimr_pkg::POS_DONE +: NCH]) != '0 ||
                  (ovr & mask[aimr_pkg::POS_OVR +: NCH]) != '0 ||
                  (ready && mask[aimr_pkg::POS_READY]) ||
                  (govr && mask[aimr_pkg::POS_GOVR]) ||
                  (i_rx_count_end && mask[aimr_pkg::POS_RXEND]) ||
                  (i_rx_both_empty && mask[aimr_pkg::POS_RXFULL]);
    endproperty
    a_irq_cause: assert property (p_irq_cause)
        else $error("interrupt without enabled flag");

    // Looks one edge ahead, so the very first edge before any reset is not judged
    property p_reset_mask;
        @(posedge i_clock)
        i_rst |=> mask == aimr_pkg::MASK_RESET && !o_irq;
    endproperty
    a_reset_mask: assert property (p_reset_mask)
        else $error("enables not cleared by reset");

    property p_ack_once;
        @(posedge i_clock) disable iff (i_rst)
        o_wb_ack |=> !o_wb_ack;
    endproperty
    a_ack_once: assert property (p_ack_once)
        else $error("ack held longer than one cycle");

    property p_mask_quiet;
        @(posedge i_clock) disable iff (i_rst)
        !(wr && (i_wb_adr == aimr_pkg::OFS_IRQ_SET || i_wb_adr == aimr_pkg::OFS_IRQ_CLR))
        |=> $stable(mask);
    endproperty
    a_mask_quiet: assert property (p_mask_quiet)
        else $error("enables changed without a set or clear write");

    property p_ack_next;
        @(posedge i_clock) disable iff (i_rst)
        first |=> o_wb_ack;
    endproperty
    a_ack_next: assert property (p_ack_next)
        else $error("request not acknowledged in the next cycle");

endmodule : aimr_regs
`default_nettype wire

// [test/tb.sv]
// Self-checking bench for the converter interrupt mask and result bank.
// Assumes aimr_regs with package defaults; the bench is the Wishbone master.
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin \
    compares++; \
    if ((got) !== (exp)) begin \
        n_errors++; \
        $display("MISMATCH %0t got %h expected %h", $time, got, exp); \
    end \
end
module tb;
    typedef struct packed {
        logic        chk;
        logic        irq;
        logic [31:0] dat;
    } aimr_note_t;

    localparam logic [7:0] A_STAT = aimr_pkg::OFS_STATUS;
    localparam logic [7:0] A_SET  = aimr_pkg::OFS_IRQ_SET;
    localparam logic [7:0] A_CLR  = aimr_pkg::OFS_IRQ_CLR;
    localparam logic [7:0] A_VIEW = aimr_pkg::OFS_IRQ_VIEW;
    localparam logic [7:0] A_RES  = aimr_pkg::OFS_RESULT0;

    logic        i_clock = 1'h0;
    logic        i_rst   = 1'h1;
    logic        cyc     = 1'h0;
    logic        stb     = 1'h0;
    logic        we      = 1'h0;
    logic [7:0]  adr     = 8'h00;
    logic [31:0] wdat    = 32'h0;
    logic [3:0]  sel     = 4'h0;
    logic [3:0]  done    = 4'h0;
    logic [3:0]  en      = 4'h0;
    logic [3:0]  ovr     = 4'h0;
    logic [9:0]  cdata   = 10'h000;
    logic        govr    = 1'h0;
    logic        ldr     = 1'h0;
    logic        rxe     = 1'h0;
    logic        rxf     = 1'h0;
    logic [31:0] rdat;
    logic        ack;
    logic        irq;
    // Bench model of mask, sticky flags and results
    logic [31:0] m       = 32'h0;
    logic [31:0] fl      = 32'h0;
    logic [9:0]  res [4] = '{10'h000, 10'h000, 10'h000, 10'h000};
    logic [31:0] seed    = 32'h000062b7;
    logic [31:0] d;
    logic [31:0] r;
    logic [1:0]  k;
    int          n_errors = 0;
    int          compares = 0;
    aimr_note_t  notes [$];
    aimr_note_t  nt;

    aimr_regs i_aimr_regs (
        .i_clock          (i_clock),
        .i_rst            (i_rst),
        .i_wb_cyc         (cyc),
        .i_wb_stb         (stb),
        .i_wb_we          (we),
        .i_wb_adr         (adr),
        .i_wb_dat         (wdat),
        .i_wb_sel         (sel),
        .o_wb_dat         (rdat),
        .o_wb_ack         (ack),
        .i_conv_done      (done),
        .i_conv_data      (cdata),
        .i_chan_en        (en),
        .i_chan_overrun   (ovr),
        .i_global_overrun (govr),
        .i_last_data_read (ldr),
        .i_rx_count_end   (rxe),
        .i_rx_both_empty  (rxf),
        .o_irq            (irq)
    );

    // 50 MHz clock
    always #10 i_clock = ~i_clock;

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    function automatic logic [31:0] bm(input logic [3:0] s);
        return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction : bm

    // Rx bits are raw levels, so they join the sticky flags only here
    function automatic logic [31:0] stat();
        return fl | {12'h000, rxf, rxe, 18'h00000};
    endfunction : stat

    task automatic end_sim();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_sim

    // One classic cycle; the note is queued before the request goes out
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] dt,
                      input logic [3:0] s, input logic c, input logic [31:0] e);
        notes.push_back('{c, |(stat() & m), e});
        @(posedge i_clock);
        cyc  <= 1'h1;
        stb  <= 1'h1;
        we   <= w;
        adr  <= a;
        wdat <= dt;
        sel  <= s;
        // No cycle count assumed here; only the watchdog ends a lost answer
        do begin
            @(posedge i_clock);
        end while (ack !== 1'h1);
        cyc <= 1'h0;
        stb <= 1'h0;
    endtask : wb

    // One conversion end on channel c with enables e
    task automatic conv(input logic [1:0] c, input logic [3:0] e, input logic [9:0] v);
        @(posedge i_clock);
        en    <= e;
        done  <= 4'h1 << c;
        cdata <= v;
        @(posedge i_clock);
        done <= 4'h0;
        fl[3:0] = fl[3:0] & e;
        if (e[c]) begin
            res[c] = v;
            fl[c]  = 1'h1;
            fl[16] = 1'h1;
        end
    endtask : conv

    // Monitor: every ack retires the oldest note
    always @(posedge i_clock) begin
        if (ack === 1'h1) begin
            if (notes.size() == 0) begin
                n_errors++;
                $display("MISMATCH %0t ack without request", $time);
            end else begin
                nt = notes.pop_front();
                if (nt.chk) begin
                    `CHK(rdat, nt.dat)
                    `CHK(irq, nt.irq)
                end
            end
        end
    end

    // Watchdog, far beyond the roughly 600 cycles the run needs
    initial begin
        repeat (20000) @(posedge i_clock);
        n_errors++;
        end_sim();
    end

    initial begin
        repeat (8) @(posedge i_clock);
        i_rst <= 1'h0;
        wb(1'h0, A_VIEW, 32'h0, 4'hf, 1'h1, 32'h0);
        // Walk each defined mask bit (IRQ_BITS) alone through set, view and clear
        for (int b = 0; b < 32; b++) begin
            if (aimr_pkg::IRQ_BITS[b]) begin
                wb(1'h1, A_SET, 32'h1 << b, 4'hf, 1'h0, 32'h0);
                wb(1'h0, A_VIEW, 32'h0, 4'hf, 1'h1, 32'h1 << b);
                wb(1'h1, A_CLR, 32'h1 << b, 4'hf, 1'h0, 32'h0);
                wb(1'h0, A_VIEW, 32'h0, 4'hf, 1'h1, 32'h0);
            end
        end
        // Random set and clear with byte lanes; view writes must bounce
        repeat (24) begin
            d = rnd();
            r = rnd();
            if (r[0]) begin
                wb(1'h1, A_SET, d, r[7:4], 1'h0, 32'h0);
                m = m | (d & bm(r[7:4]) & aimr_pkg::IRQ_BITS);
            end else begin
                wb(1'h1, A_CLR, d, r[7:4], 1'h0, 32'h0);
                m = m & ~(d & bm(r[7:4]));
            end
            wb(1'h1, A_VIEW, r, 4'hf, 1'h0, 32'h0);
            wb(1'h0, A_VIEW, 32'h0, 4'hf, 1'h1, m);
        end
        // Reset in mid-run, with enables set, must drop every one of them
        @(posedge i_clock);
        i_rst <= 1'h1;
        repeat (2) @(posedge i_clock);
        i_rst <= 1'h0;
        m = 32'h0;
        wb(1'h0, A_VIEW, 32'h0, 4'hf, 1'h1, 32'h0);
        wb(1'h1, A_CLR, 32'hffffffff, 4'hf, 1'h0, 32'h0);
        m = 32'h0;
        wb(1'h1, A_SET, 32'h0001000f, 4'hf, 1'h0, 32'h0);
        m = 32'h0001000f;
        // Conversions with random enables, some on disabled channels
        repeat (16) begin
            r = rnd();
            k = r[1:0];
            conv(k, r[7:4], r[17:8]);
            wb(1'h0, A_STAT, 32'h0, 4'hf, 1'h1, stat());
            repeat (2) begin
                wb(1'h0, A_RES + {4'h0, k, 2'h0}, 32'h0, 4'hf, 1'h1, {22'h0, res[k]});
                fl[k] = 1'h0;
            end
        end
        // Overruns and result-ready clear, then clear-on-read
        wb(1'h1, A_SET, 32'h00020f00, 4'hf, 1'h0, 32'h0);
        m = m | 32'h00020f00;
        @(posedge i_clock);
        ovr  <= 4'h5;
        govr <= 1'h1;
        ldr  <= 1'h1;
        @(posedge i_clock);
        ovr  <= 4'h0;
        govr <= 1'h0;
        ldr  <= 1'h0;
        fl = (fl | 32'h00020500) & ~32'h00010000;
        repeat (2) begin
            wb(1'h0, A_STAT, 32'h0, 4'hf, 1'h1, stat());
            fl = fl & ~32'h00020f00;
        end
        // Clear remaining sticky flags by writing ones
        wb(1'h1, A_STAT, aimr_pkg::IRQ_BITS, 4'hf, 1'h0, 32'h0);
        fl = 32'h0;
        wb(1'h0, A_STAT, 32'h0, 4'hf, 1'h1, 32'h0);
        // Receive levels raise the interrupt only while enabled
        @(posedge i_clock);
        rxe <= 1'h1;
        rxf <= 1'h1;
        wb(1'h1, A_SET, 32'h000c0000, 4'hf, 1'h0, 32'h0);
        m = m | 32'h000c0000;
        wb(1'h0, A_VIEW, 32'h0, 4'hf, 1'h1, m);
        wb(1'h1, A_CLR, 32'h000c0000, 4'hf, 1'h0, 32'h0);
        m = m & ~32'h000c0000;
        wb(1'h0, A_STAT, 32'h0, 4'hf, 1'h1, stat());
        // Unmapped place, write-only read, and a write to a result
        wb(1'h1, 8'h80, rnd(), 4'hf, 1'h0, 32'h0);
        wb(1'h0, 8'h80, 32'h0, 4'hf, 1'h1, 32'h0);
        wb(1'h0, A_SET, 32'h0, 4'hf, 1'h1, 32'h0);
        wb(1'h1, A_RES, 32'h000003ff, 4'hf, 1'h0, 32'h0);
        wb(1'h0, A_RES, 32'h0, 4'hf, 1'h1, {22'h0, res[0]});
        repeat (3) @(posedge i_clock);
        end_sim();
    end
endmodule : tb
`default_nettype wire
